// File: src/clkgen_map.vh
// register map, field positions, reset values and counts of the cpu clock selector
`ifndef CLKGEN_MAP_VH
`define CLKGEN_MAP_VH

// ======================================================================
// byte addresses
`define SUBOSC_MODE_ADDR     16'hFFF0
`define SUBCLK_CTRL_ADDR     16'hFFF2
`define PROC_CLK_CTRL_ADDR   16'hFFFB

// ======================================================================
// reset values
`define SUBOSC_MODE_RST      8'h00
`define SUBCLK_CTRL_RST      8'h00
`define PROC_CLK_CTRL_RST    8'h02

// ======================================================================
// field positions
`define MAIN_OSC_STOP_BIT    7
`define MAIN_DIV_SEL_BIT     1
`define CLK_STATUS_BIT       5
`define SUBCLK_SEL_BIT       4
`define FB_RES_OFF_BIT       1
`define SUB_OSC_STOP_BIT     0

// ======================================================================
// writable masks, all other bits read as zero except bit 5 of the sub clock control, the live source status
`define PROC_CLK_CTRL_MASK   8'h82
`define SUBOSC_MODE_MASK     8'h03
`define SUBCLK_CTRL_MASK     8'h10

// ======================================================================
// timing counts
`define MAIN_DIV_RATIO       3'h4
`define SUB_DIV_RATIO        3'h2
`define STEP_CPU_CLOCKS      2
`define STAB_WAIT_BITS       15

`endif

// File: src/osc_edge_tick.v
// rising-edge tick of one sampled oscillator, gated by its enable
`timescale 1ns/1ps
module osc_edge_tick (
    input  wire i_mclk,
    input  wire i_reset,
    input  wire i_osc,
    input  wire i_enable,
    output reg  o_tick
);

// ======================================================================
// edge detect
reg prev_q;

// a stopped oscillator yields no ticks even if the pin still toggles
always @(posedge i_mclk) begin
    if (i_reset) begin
        prev_q <= 1'b0;
        o_tick <= 1'b0;
    end else begin
        prev_q <= i_osc;
        o_tick <= i_enable & i_osc & ~prev_q;
    end
end

endmodule

// File: src/cpu_step_gen.v
// cpu clock ticks and instruction step pulses from the selected source
`timescale 1ns/1ps
`include "clkgen_map.vh"
module cpu_step_gen (
    input  wire i_mclk,
    input  wire i_reset,
    input  wire i_main_tick,
    input  wire i_sub_tick,
    input  wire i_run,
    input  wire i_sel_sub,
    input  wire i_sel_div,
    output reg  o_cpu_tick,
    output reg  o_cpu_step
);

// ======================================================================
// prescaler
reg  [2:0] pre_q;
reg  [1:0] sel_q;
reg        half_q;
wire       src_tick;
wire [2:0] ratio;
wire       sel_chg;

// both bits set acts as sub clock over two
assign src_tick = i_sel_sub ? i_sub_tick : i_main_tick;
assign ratio    = i_sel_sub ? `SUB_DIV_RATIO : (i_sel_div ? `MAIN_DIV_RATIO : 3'h1);
assign sel_chg  = (sel_q != {i_sel_sub, i_sel_div});

// counters restart on a switch, so no short period
// a step is two cpu clock periods
always @(posedge i_mclk) begin
    if (i_reset) begin
        pre_q      <= 3'h0;
        sel_q      <= 2'h1;
        half_q     <= 1'b0;
        o_cpu_tick <= 1'b0;
        o_cpu_step <= 1'b0;
    end else begin
        sel_q      <= {i_sel_sub, i_sel_div};
        o_cpu_tick <= 1'b0;
        o_cpu_step <= 1'b0;
        if (sel_chg || !i_run) begin
            pre_q  <= 3'h0;
            half_q <= 1'b0;
        end else if (src_tick) begin
            if (pre_q == ratio - 3'h1) begin
                pre_q      <= 3'h0;
                o_cpu_tick <= 1'b1;
                half_q     <= ~half_q;
                o_cpu_step <= half_q;
            end else begin
                pre_q <= pre_q + 3'h1;
            end
        end
    end
end

endmodule

// File: src/clock_select_top.v
// cpu clock selector with two oscillator controls and three control registers
`timescale 1ns/1ps
`include "clkgen_map.vh"
module clock_select_top #(
    parameter STAB_BITS = `STAB_WAIT_BITS
) (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire        i_main_osc_in,
    input  wire        i_sub_osc_in,
    input  wire        i_stop_mode,
    input  wire [15:0] i_addr,
    input  wire        i_byte_we,
    input  wire [7:0]  i_wdata,
    input  wire        i_bit_we,
    input  wire [2:0]  i_bit_sel,
    input  wire        i_bit_val,
    input  wire        i_rd_en,
    output reg  [7:0]  o_rdata,
    output reg         o_main_osc_en,
    output reg         o_sub_osc_en,
    output reg         o_feedback_resistor_off,
    output reg         o_cpu_run,
    output wire        o_cpu_tick,
    output wire        o_cpu_step
);

// ======================================================================
// registers and state
reg  [7:0]           proc_clk_ctrl_q;
reg  [7:0]           subosc_mode_q;
reg  [7:0]           subclk_ctrl_q;
reg                  cur_sub_q;
reg                  cur_div_q;
reg  [STAB_BITS-1:0] stab_cnt_q;
reg                  stab_done_q;
reg  [7:0]           proc_clk_ctrl_d;
reg  [7:0]           subosc_mode_d;
reg  [7:0]           subclk_ctrl_d;
reg  [7:0]           rdata_d;
reg  [1:0]           sw_state_q;
wire                 main_tick;
wire                 sub_tick;
wire                 wr_any;
wire                 want_sub;
wire                 want_div;
wire                 can_apply;
wire                 sel_differs;
wire                 at_boundary;
wire [1:0]           osc_pin;
wire [1:0]           osc_en;
wire [1:0]           osc_tick;

// byte write replaces, bit write changes one bit
function [7:0] merged;
    input [7:0] old;
    input [7:0] mask;
    input       byte_we;
    input [7:0] wdata;
    input [2:0] sel;
    input       val;
    reg   [7:0] tmp;
    begin
        tmp = old;
        if (byte_we)
            tmp = wdata;
        else
            tmp[sel] = val;
        merged = tmp & mask;
    end
endfunction

assign wr_any = i_byte_we | i_bit_we;

// ======================================================================
// register decode, shared by the write and read paths
localparam [1:0] REG_NONE   = 2'h0;
localparam [1:0] REG_PROC   = 2'h1;
localparam [1:0] REG_SUBOSC = 2'h2;
localparam [1:0] REG_SUBCLK = 2'h3;

// selection switch states
localparam [1:0] SW_HOLD    = 2'h0;
localparam [1:0] SW_PEND    = 2'h1;

// unmapped addresses fall to none, so they neither write nor read back
function [1:0] reg_index;
    input [15:0] addr;
    begin
        case (addr)
            `PROC_CLK_CTRL_ADDR: reg_index = REG_PROC;
            `SUBOSC_MODE_ADDR:   reg_index = REG_SUBOSC;
            `SUBCLK_CTRL_ADDR:   reg_index = REG_SUBCLK;
            default:             reg_index = REG_NONE;
        endcase
    end
endfunction

// ======================================================================
// oscillator ticks, only while enabled
// bit 0 is the main oscillator, bit 1 the sub oscillator
assign osc_pin   = {i_sub_osc_in, i_main_osc_in};
assign osc_en    = {o_sub_osc_en, o_main_osc_en};
assign main_tick = osc_tick[0];
assign sub_tick  = osc_tick[1];

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_osc
        osc_edge_tick u_tick (
            .i_mclk   (i_mclk),
            .i_reset  (i_reset),
            .i_osc    (osc_pin[gi]),
            .i_enable (osc_en[gi]),
            .o_tick   (osc_tick[gi])
        );
    end
endgenerate

// ======================================================================
// register next values
// reserved bits masked off
always @* begin
    proc_clk_ctrl_d = proc_clk_ctrl_q;
    subosc_mode_d   = subosc_mode_q;
    subclk_ctrl_d   = subclk_ctrl_q;
    if (wr_any) begin
        case (reg_index(i_addr))
            REG_PROC: begin
                proc_clk_ctrl_d = merged(proc_clk_ctrl_q, `PROC_CLK_CTRL_MASK, i_byte_we,
                                         i_wdata, i_bit_sel, i_bit_val);
                // main stop set only under sub
                // a pending switch back to main blocks it too, else main dies under the cpu
                if (!cur_sub_q || !want_sub)
                    proc_clk_ctrl_d[`MAIN_OSC_STOP_BIT] = proc_clk_ctrl_d[`MAIN_OSC_STOP_BIT] &
                                                          proc_clk_ctrl_q[`MAIN_OSC_STOP_BIT];
            end
            // only this register stops the sub oscillator
            REG_SUBOSC: begin
                subosc_mode_d = merged(subosc_mode_q, `SUBOSC_MODE_MASK, i_byte_we,
                                       i_wdata, i_bit_sel, i_bit_val);
            end
            // status bit not writable, mask drops it
            REG_SUBCLK: begin
                subclk_ctrl_d = merged(subclk_ctrl_q, `SUBCLK_CTRL_MASK, i_byte_we,
                                       i_wdata, i_bit_sel, i_bit_val);
            end
            default: begin
                subclk_ctrl_d = subclk_ctrl_q;
            end
        endcase
    end
end

// ======================================================================
// register writes
// reset values
always @(posedge i_mclk) begin
    if (i_reset) begin
        proc_clk_ctrl_q <= `PROC_CLK_CTRL_RST;
        subosc_mode_q   <= `SUBOSC_MODE_RST;
        subclk_ctrl_q   <= `SUBCLK_CTRL_RST;
    end else begin
        proc_clk_ctrl_q <= proc_clk_ctrl_d;
        subosc_mode_q   <= subosc_mode_d;
        subclk_ctrl_q   <= subclk_ctrl_d;
    end
end

// ======================================================================
// register reads, one cycle latency
// live source status in bit 5
always @* begin
    rdata_d = o_rdata;
    if (i_rd_en) begin
        case (reg_index(i_addr))
            REG_PROC:   rdata_d = proc_clk_ctrl_q;
            REG_SUBOSC: rdata_d = subosc_mode_q;
            REG_SUBCLK: rdata_d = subclk_ctrl_q | {2'h0, cur_sub_q, 5'h00};
            default:    rdata_d = 8'h00;
        endcase
    end
end

// read data holds until the next read
always @(posedge i_mclk) begin
    if (i_reset) begin
        o_rdata <= 8'h00;
    end else begin
        o_rdata <= rdata_d;
    end
end

// ======================================================================
// oscillator enables
// stop mode or stop bit halts main oscillator
// sub oscillator off when bit 0 set
always @(posedge i_mclk) begin
    if (i_reset) begin
        o_main_osc_en           <= 1'b0;
        o_sub_osc_en            <= 1'b0;
        o_feedback_resistor_off <= 1'b0;
    end else begin
        o_main_osc_en           <= ~proc_clk_ctrl_q[`MAIN_OSC_STOP_BIT] & ~i_stop_mode;
        o_sub_osc_en            <= ~subosc_mode_q[`SUB_OSC_STOP_BIT];
        o_feedback_resistor_off <= subosc_mode_q[`FB_RES_OFF_BIT];
    end
end

// ======================================================================
// stabilisation wait after reset, counted in main oscillator periods
// cpu held until 2^15 main ticks seen
always @(posedge i_mclk) begin
    if (i_reset) begin
        stab_cnt_q  <= {STAB_BITS{1'b0}};
        stab_done_q <= 1'b0;
        o_cpu_run   <= 1'b0;
    end else begin
        if (!stab_done_q && main_tick) begin
            stab_cnt_q <= stab_cnt_q + {{(STAB_BITS-1){1'b0}}, 1'b1};
            if (&stab_cnt_q)
                stab_done_q <= 1'b1;
        end
        o_cpu_run <= stab_done_q;
    end
end

// ======================================================================
// applied selection
assign want_sub = subclk_ctrl_q[`SUBCLK_SEL_BIT];
assign want_div = proc_clk_ctrl_q[`MAIN_DIV_SEL_BIT];
assign sel_differs = (want_sub != cur_sub_q) | (want_div != cur_div_q);
assign at_boundary = o_cpu_step | ~o_cpu_run;
// a switch waits for the target oscillator, so the cpu never switches onto a dead clock
assign can_apply   = want_sub ? o_sub_osc_en :
                     (o_main_osc_en & ~proc_clk_ctrl_q[`MAIN_OSC_STOP_BIT] & stab_done_q);

// new setting taken at the end of a step
// stop bit cannot halt main while still selected, stop mode still can
always @(posedge i_mclk) begin
    if (i_reset) begin
        sw_state_q <= SW_HOLD;
        cur_sub_q  <= 1'b0;
        cur_div_q  <= 1'b1;
    end else begin
        case (sw_state_q)
            SW_HOLD: begin
                if (sel_differs)
                    sw_state_q <= SW_PEND;
            end
            // software may take the request back before it is applied
            SW_PEND: begin
                if (!sel_differs) begin
                    sw_state_q <= SW_HOLD;
                end else if (at_boundary && can_apply) begin
                    cur_sub_q  <= want_sub;
                    cur_div_q  <= want_div;
                    sw_state_q <= SW_HOLD;
                end
            end
            default: begin
                sw_state_q <= SW_HOLD;
            end
        endcase
    end
end

// ======================================================================
// cpu clock and step generation
// glitch free switching inside the generator
cpu_step_gen u_step (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_main_tick (main_tick),
    .i_sub_tick  (sub_tick),
    .i_run       (o_cpu_run),
    .i_sel_sub   (cur_sub_q),
    .i_sel_div   (cur_div_q),
    .o_cpu_tick  (o_cpu_tick),
    .o_cpu_step  (o_cpu_step)
);

endmodule

// File: verification/osc_model.sv
// resonator model: square wave while enabled, flat low while stopped
`timescale 1ns/1ps
module osc_model #(
    parameter HALF_NS = 30
) (
    input  wire i_enable,
    output reg  o_osc
);
    // ==========================================
    // oscillation
    // a stopped resonator sits low, never at a stale level
    initial o_osc = 1'b0;
    always begin
        #(HALF_NS);
        o_osc = i_enable ? ~o_osc : 1'b0;
    end
endmodule

// File: verification/clock_select_checker.sv
// port assertions for the cpu clock selector
`timescale 1ns/1ps
module clock_select_checker #(
    parameter STAB_BITS = 15
) (
    input wire        i_mclk,
    input wire        i_reset,
    input wire        i_stop_mode,
    input wire [15:0] i_addr,
    input wire        i_byte_we,
    input wire [7:0]  i_wdata,
    input wire        o_main_osc_en,
    input wire        o_sub_osc_en,
    input wire        o_feedback_resistor_off,
    input wire        o_cpu_run,
    input wire        o_cpu_tick,
    input wire        o_cpu_step
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // ==========================================
    // register writes to the sub oscillator mode
    sequence s_sub_off_wr;
        i_byte_we && i_addr == 16'hFFF0 && i_wdata[0];
    endsequence
    sequence s_fb_res_wr;
        i_byte_we && i_addr == 16'hFFF0 && i_wdata[1];
    endsequence
    property p_sub_stop;
        s_sub_off_wr |-> ##[1:2] !o_sub_osc_en;
    endproperty
    a_sub_stop: assert property (p_sub_stop) else $error("sub osc still on");
    property p_fb_res;
        s_fb_res_wr |-> ##[1:2] o_feedback_resistor_off;
    endproperty
    a_fb_res: assert property (p_fb_res) else $error("resistor not cut");
    // ==========================================
    // oscillator enables
    property p_main_stop;
        i_stop_mode [*3] |-> !o_main_osc_en;
    endproperty
    a_main_stop: assert property (p_main_stop) else $error("main osc runs in stop");
    // main held off through reset, starts one edge later
    property p_main_rst;
        $fell(i_reset) |-> !o_main_osc_en ##1 o_main_osc_en;
    endproperty
    a_main_rst: assert property (p_main_rst) else $error("main start wrong");
    // ==========================================
    // cpu tick and step shape
    property p_tick_run;
        o_cpu_tick |-> o_cpu_run;
    endproperty
    a_tick_run: assert property (p_tick_run) else $error("tick before run");
    property p_step_tick;
        o_cpu_step |-> o_cpu_tick;
    endproperty
    a_step_tick: assert property (p_step_tick) else $error("step off tick");
    property p_tick_gap;
        o_cpu_tick |=> !o_cpu_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("runt cpu tick");
    property p_step_gap;
        o_cpu_step |=> !o_cpu_step [*3];
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("short step");
endmodule
bind clock_select_top clock_select_checker #(.STAB_BITS(STAB_BITS)) clock_select_checker_i (
    .i_mclk, .i_reset, .i_stop_mode, .i_addr, .i_byte_we, .i_wdata, .o_main_osc_en,
    .o_sub_osc_en, .o_feedback_resistor_off, .o_cpu_run, .o_cpu_tick, .o_cpu_step);

// File: verification/clock_select_top_test.sv
// self-checking bench for the cpu clock selector
`timescale 1ns/1ps
module clock_select_top_test;
    localparam MH = 3;
    localparam SH = 20;
    reg         i_mclk = 1'b0;
    reg         i_reset = 1'b1;
    reg         i_stop_mode = 1'b0;
    reg  [15:0] i_addr = 16'h0000;
    reg         i_byte_we = 1'b0;
    reg  [7:0]  i_wdata = 8'h00;
    reg         i_bit_we = 1'b0;
    reg  [2:0]  i_bit_sel = 3'h0;
    reg         i_bit_val = 1'b0;
    reg         i_rd_en = 1'b0;
    wire        i_main_osc_in, i_sub_osc_in, o_main_osc_en, o_sub_osc_en;
    wire        o_feedback_resistor_off, o_cpu_run, o_cpu_tick, o_cpu_step;
    wire [7:0]  o_rdata;
    integer     err_total = 0;
    integer     comparisons = 0;
    integer     n;
    // ==========================================
    // clock, resonators, design
    always #5 i_mclk = ~i_mclk;
    osc_model #(.HALF_NS(MH * 10)) osc_model_i (.i_enable(o_main_osc_en), .o_osc(i_main_osc_in));
    osc_model #(.HALF_NS(SH * 10)) osc_sub_i (.i_enable(o_sub_osc_en), .o_osc(i_sub_osc_in));
    clock_select_top #(.STAB_BITS(4)) clock_select_top_i (
        .i_mclk, .i_reset, .i_main_osc_in, .i_sub_osc_in, .i_stop_mode, .i_addr, .i_byte_we,
        .i_wdata, .i_bit_we, .i_bit_sel, .i_bit_val, .i_rd_en, .o_rdata, .o_main_osc_en,
        .o_sub_osc_en, .o_feedback_resistor_off, .o_cpu_run, .o_cpu_tick, .o_cpu_step);
    // ==========================================
    // access tasks, all driven at the falling edge
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input string name, input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(negedge i_mclk);
            i_addr = a;
            i_wdata = d;
            i_byte_we = 1'b1;
            @(negedge i_mclk);
            i_byte_we = 1'b0;
        end
    endtask
    task wbit(input [15:0] a, input [2:0] s, input v);
        begin
            @(negedge i_mclk);
            i_addr = a;
            i_bit_sel = s;
            i_bit_val = v;
            i_bit_we = 1'b1;
            @(negedge i_mclk);
            i_bit_we = 1'b0;
        end
    endtask
    task rd(input [15:0] a, input [7:0] exp);
        begin
            @(negedge i_mclk);
            i_addr = a;
            i_rd_en = 1'b1;
            @(negedge i_mclk);
            i_rd_en = 1'b0;
            chk("read data", o_rdata, exp);
        end
    endtask
    // bounded wait for one step pulse, c counts the cycles taken
    task wait_step(output integer c);
        begin
            c = 0;
            do begin
                @(negedge i_mclk);
                c = c + 1;
            end while (o_cpu_step !== 1'b1 && c < 5000);
            if (c >= 5000) begin
                err_total = err_total + 1;
                test_done;
            end
        end
    endtask
    // a switch may lag a few steps, so settle before measuring
    task gap(input [7:0] exp);
        begin
            repeat (3) wait_step(n);
            wait_step(n);
            chk("step period", n[7:0], exp);
        end
    endtask
    // ==========================================
    // main sequence; software writes keep reserved bits at zero
    initial begin
        repeat (3) @(negedge i_mclk);
        i_reset = 1'b0;
        rd(16'hFFFB, 8'h02);
        rd(16'hFFF0, 8'h00);
        rd(16'hFFF2, 8'h00);
        rd(16'hFFF1, 8'h00);
        n = 0;
        while (o_cpu_run !== 1'b1 && n < 2000) begin
            @(negedge i_mclk);
            n = n + 1;
        end
        chk("cpu run", {7'h00, o_cpu_run}, 8'h01);
        gap(16 * MH);
        wbit(16'hFFFB, 3'h1, 1'b0);
        gap(4 * MH);
        wbit(16'hFFFB, 3'h7, 1'b1);
        rd(16'hFFFB, 8'h00);
        wr(16'hFFFB, 8'h02);
        wr(16'hFFF2, 8'h10);
        gap(8 * SH);
        rd(16'hFFF2, 8'h30);
        wr(16'hFFFB, 8'h82);
        repeat (3) @(negedge i_mclk);
        chk("main enable", {7'h00, o_main_osc_en}, 8'h00);
        rd(16'hFFFB, 8'h82);
        gap(8 * SH);
        wr(16'hFFF2, 8'h20);
        rd(16'hFFF2, 8'h20);
        wr(16'hFFFB, 8'h02);
        gap(16 * MH);
        rd(16'hFFF2, 8'h00);
        wr(16'hFFF0, 8'h03);
        repeat (3) @(negedge i_mclk);
        chk("sub enable", {7'h00, o_sub_osc_en}, 8'h00);
        chk("resistor off", {7'h00, o_feedback_resistor_off}, 8'h01);
        wbit(16'hFFF0, 3'h0, 1'b0);
        repeat (3) @(negedge i_mclk);
        chk("sub enable", {7'h00, o_sub_osc_en}, 8'h01);
        i_stop_mode = 1'b1;
        repeat (4) @(negedge i_mclk);
        chk("main in stop", {7'h00, o_main_osc_en}, 8'h00);
        chk("sub in stop", {7'h00, o_sub_osc_en}, 8'h01);
        i_stop_mode = 1'b0;
        test_done;
    end
endmodule
